//--- verilog/tsp_pkg.sv
`default_nettype none
package tsp_pkg;
  // Counter and compare widths
  localparam int TSP_CNT_W = 16;
  localparam int TSP_CMP_P_W = 8;
  // Mode selection encodings
  typedef enum logic [1:0] {
    TSP_MODE_COMPARE = 2'b00,
    TSP_MODE_CAPTURE = 2'b01,
    TSP_MODE_PULSE = 2'b10,
    TSP_MODE_TIMER = 2'b11
  } tsp_mode_t;
  // Pin function encodings
  localparam logic [1:0] TSP_PF_SINGLE = 2'b11;
  localparam logic [1:0] TSP_PF_CAP_RISE = 2'b00;
  localparam logic [1:0] TSP_PF_CAP_FALL = 2'b01;
  localparam logic [1:0] TSP_PF_CAP_BOTH = 2'b10;
  localparam logic [1:0] TSP_PF_CAP_OFF = 2'b11;
  // Reset values and zero/one constants
  localparam logic [15:0] TSP_CNT_RST = 16'h0000;
  localparam logic [15:0] TSP_CMPA_RST = 16'h0000;
  localparam logic [7:0] TSP_CMPP_ZERO = 8'h00;
  localparam logic [15:0] TSP_CNT_ONE = 16'h0001;
  // Synchroniser depth
  localparam int TSP_SYNC_STAGES = 3;
endpackage : tsp_pkg
`default_nettype wire

//--- verilog/tsp_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module tsp_pin_sync
  import tsp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_pin,
  output logic o_level
);
  // Three-stage chain; stage one only feeds stage two
  logic [TSP_SYNC_STAGES-1:0] chain_ff;
  logic [TSP_SYNC_STAGES-1:0] nxt_chain;
  logic level_ff;
  logic nxt_level;

  // Shift in and accept a change once last two stages agree
  always_comb begin
    nxt_chain = {chain_ff[TSP_SYNC_STAGES-2:0], i_pin};
    nxt_level = level_ff;
    if (chain_ff[1] == chain_ff[2]) begin
      nxt_level = chain_ff[2];
    end
  end

  // Register stage
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      chain_ff <= '0;
      level_ff <= 1'b0;
    end else begin
      chain_ff <= nxt_chain;
      level_ff <= nxt_level;
    end
  end

  assign o_level = level_ff;
endmodule : tsp_pin_sync
`default_nettype wire

//--- verilog/tsp_timer.sv
// Notes on behaviour
// - Counter-on rise starts counter and pulse
// - Trigger pin edge sets counter-on in pulse mode
// - Pulse ends on clear or compare A
// - Compare A match clears on, stops, interrupts
// - Counter zeroed only on counter-on rise in pulse mode
// - Compare P, clear source, swap ignored here
// - Pin function picks capture edge type
// - Capture counter starts on counter-on rise
// - Active edge copies counter into A, interrupts
// - Counter free-runs until counter-on falls
// - Compare P match zeroes counter, interrupts
// - Pin function 11 disables capture only
// - Capture mode has no output function
// - Compare P zero runs to full count
// - Compare P matches top byte of counter plus one
// - Compare A and counter are 16 bits
`timescale 1ns/1ns
`default_nettype none
module tsp_timer
  import tsp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_tick,
  input wire logic i_mode_select_hi,
  input wire logic i_mode_select_lo,
  input wire logic i_pin_function_hi,
  input wire logic i_pin_function_lo,
  input wire logic i_clear_source_select,
  input wire logic i_duty_period_swap,
  input wire logic i_output_initial_level,
  input wire logic i_output_polarity,
  input wire logic i_counter_on_wr,
  input wire logic i_counter_on_wdata,
  input wire logic i_compare_a_wr,
  input wire logic [TSP_CNT_W-1:0] i_compare_a_wdata,
  input wire logic [TSP_CMP_P_W-1:0] i_compare_p_value,
  input wire logic i_ext_trigger_pin,
  input wire logic i_capture_input_pin,
  output logic o_counter_on,
  output logic [TSP_CNT_W-1:0] o_counter,
  output logic [TSP_CNT_W-1:0] o_compare_a_value,
  output logic o_timer_output,
  output logic o_timer_irq
);
  tsp_mode_t mode; // Decoded mode field
  logic [1:0] pin_func; // Pin function field
  logic trig_lvl; // Synchronised trigger pin
  logic cap_lvl; // Synchronised capture pin
  logic trig_prev_ff; // Previous trigger level
  logic cap_prev_ff; // Previous capture level
  logic on_ff; // Counter-on bit
  logic on_prev_ff; // Counter-on one cycle ago
  logic [TSP_CNT_W-1:0] cnt_ff; // Timer counter
  logic [TSP_CNT_W-1:0] cmpa_ff; // Compare A register
  logic out_ff; // Output pin level
  logic irq_ff; // Interrupt pulse
  logic nxt_on;
  logic [TSP_CNT_W-1:0] nxt_cnt;
  logic [TSP_CNT_W-1:0] nxt_cmpa;
  logic nxt_out;
  logic nxt_irq;
  logic single_mode; // Pulse mode selected
  logic cap_mode; // Capture mode selected
  logic on_rise; // Counter-on rising edge
  logic running; // Counter-on settled high
  logic trig_edge; // Trigger pin active edge
  logic cap_edge; // Selected capture edge
  logic a_match; // Compare A match this tick
  logic p_match; // Compare P match this tick
  logic [TSP_CNT_W-1:0] cnt_inc; // Counter plus one
  logic act_lvl; // Pulse active level
  logic unused_cfg; // Settings with no effect here

  assign mode = tsp_mode_t'({i_mode_select_hi, i_mode_select_lo});
  assign pin_func = {i_pin_function_hi, i_pin_function_lo};
  // Pulse mode needs both fields; software holds 11 while in use
  assign single_mode = (mode == TSP_MODE_PULSE)
    && (pin_func == TSP_PF_SINGLE);
  assign cap_mode = (mode == TSP_MODE_CAPTURE);
  // No effect in these two modes
  assign unused_cfg = i_clear_source_select ^ i_duty_period_swap;

  // Pins pass the synchroniser before any edge logic
  tsp_pin_sync u_trig_sync (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_pin(i_ext_trigger_pin),
    .o_level(trig_lvl)
  );
  tsp_pin_sync u_cap_sync (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_pin(i_capture_input_pin),
    .o_level(cap_lvl)
  );

  assign on_rise = on_ff && !on_prev_ff;
  assign running = on_ff && on_prev_ff;
  // Trigger active on the rising edge of the pin
  assign trig_edge = trig_lvl && !trig_prev_ff;
  // Active level: initial level picks it, polarity inverts it
  assign act_lvl = i_output_initial_level ^ i_output_polarity;

  // Capture edge selection
  always_comb begin
    case (pin_func)
      TSP_PF_CAP_RISE: cap_edge = cap_lvl && !cap_prev_ff;
      TSP_PF_CAP_FALL: cap_edge = !cap_lvl && cap_prev_ff;
      TSP_PF_CAP_BOTH: cap_edge = cap_lvl != cap_prev_ff;
      TSP_PF_CAP_OFF: cap_edge = 1'b0;
      default: cap_edge = 1'b0;
    endcase
  end

  // Matches are judged on timer ticks only
  assign a_match = single_mode && running && i_tick
    && (cnt_ff == cmpa_ff);
  // Shared by counting and the P compare
  assign cnt_inc = cnt_ff + TSP_CNT_ONE;
  // Clear as the count would reach P x 256, so the period is exactly
  // P x 256 ticks; zero P never matches and the counter wraps
  assign p_match = cap_mode && running && i_tick
    && (i_compare_p_value != TSP_CMPP_ZERO)
    && (cnt_inc[TSP_CNT_W-TSP_CMP_P_W-1:0] == '0)
    && (cnt_inc[TSP_CNT_W-1:TSP_CNT_W-TSP_CMP_P_W]
        == i_compare_p_value);

  // Counter-on bit; trigger set beats any clear in the same cycle
  always_comb begin
    nxt_on = on_ff;
    if (i_counter_on_wr) begin
      nxt_on = i_counter_on_wdata;
    end
    if (a_match) begin
      nxt_on = 1'b0;
    end
    if (single_mode && trig_edge) begin
      nxt_on = 1'b1;
    end
  end

  // Counter, compare A, output and interrupt
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_cmpa = cmpa_ff;
    nxt_out = out_ff;
    nxt_irq = 1'b0;
    if (i_compare_a_wr) begin
      nxt_cmpa = i_compare_a_wdata;
    end
    if (on_rise) begin
      // Only a rise zeroes the counter in pulse mode
      nxt_cnt = TSP_CNT_RST;
    end else if (a_match) begin
      // Counter holds where it matched
      nxt_irq = 1'b1;
    end else if (p_match) begin
      nxt_cnt = TSP_CNT_RST;
      nxt_irq = 1'b1;
    end else if (running && i_tick) begin
      nxt_cnt = cnt_inc;
    end
    // Capture overrides a same-cycle software write
    if (cap_mode && cap_edge) begin
      nxt_cmpa = cnt_ff;
      nxt_irq = 1'b1;
    end
    if (single_mode) begin
      if (on_rise) begin
        nxt_out = act_lvl;
      end else if (!on_ff) begin
        nxt_out = !act_lvl;
      end
    end else begin
      // Capture and other modes leave the pin idle
      nxt_out = i_output_polarity && unused_cfg && 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      on_ff <= 1'b0;
      on_prev_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
      cap_prev_ff <= 1'b0;
      cnt_ff <= TSP_CNT_RST;
      cmpa_ff <= TSP_CMPA_RST;
      out_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      on_ff <= nxt_on;
      on_prev_ff <= on_ff;
      trig_prev_ff <= trig_lvl;
      cap_prev_ff <= cap_lvl;
      cnt_ff <= nxt_cnt;
      cmpa_ff <= nxt_cmpa;
      out_ff <= nxt_out;
      irq_ff <= nxt_irq;
    end
  end

  assign o_counter_on = on_ff;
  assign o_counter = cnt_ff;
  assign o_compare_a_value = cmpa_ff;
  assign o_timer_output = out_ff;
  assign o_timer_irq = irq_ff;

  // Checks
  sequence s_on_rise;
    on_ff && !on_prev_ff;
  endsequence
  sequence s_pulse_match;
    single_mode && running && i_tick && cnt_ff == cmpa_ff && !on_rise;
  endsequence

  property p_pulse_start;
    @(posedge i_clock) disable iff (!i_rstn)
    (s_on_rise and single_mode) |=> (o_timer_output == $past(act_lvl))
      && (o_counter == TSP_CNT_RST);
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("pulse did not start on counter-on rise");

  property p_trigger_sets;
    @(posedge i_clock) disable iff (!i_rstn)
    single_mode && trig_edge |=> o_counter_on
      ##1 o_timer_output == $past(act_lvl);
  endproperty
  a_trigger_sets: assert property (p_trigger_sets)
    else $error("trigger edge did not start the pulse");

  property p_match_ends;
    @(posedge i_clock) disable iff (!i_rstn)
    s_pulse_match ##0 !trig_edge |=> !o_counter_on && o_timer_irq
      && $stable(o_counter) ##1 o_timer_output == !$past(act_lvl);
  endproperty
  a_match_ends: assert property (p_match_ends)
    else $error("compare A match did not end the pulse");

  property p_clear_ends;
    @(posedge i_clock) disable iff (!i_rstn)
    single_mode && !on_ff && !on_prev_ff
      |=> o_timer_output == !$past(act_lvl);
  endproperty
  a_clear_ends: assert property (p_clear_ends)
    else $error("pulse stayed active with counter-on low");

  property p_capture_copy;
    @(posedge i_clock) disable iff (!i_rstn)
    cap_mode && cap_edge |=> o_compare_a_value == $past(cnt_ff)
      && o_timer_irq;
  endproperty
  a_capture_copy: assert property (p_capture_copy)
    else $error("capture edge did not latch the counter");

  property p_capture_off;
    @(posedge i_clock) disable iff (!i_rstn)
    cap_mode && pin_func == TSP_PF_CAP_OFF && !i_compare_a_wr
      |=> $stable(o_compare_a_value);
  endproperty
  a_capture_off: assert property (p_capture_off)
    else $error("capture happened while disabled");

  property p_p_match;
    @(posedge i_clock) disable iff (!i_rstn)
    p_match && !on_rise |=> o_counter == TSP_CNT_RST && o_timer_irq;
  endproperty
  a_p_match: assert property (p_p_match)
    else $error("compare P match did not zero the counter");

  property p_free_run;
    @(posedge i_clock) disable iff (!i_rstn)
    cap_mode && running && i_tick && !p_match
      |=> o_counter == $past(cnt_ff) + TSP_CNT_ONE;
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("capture counter did not advance");

  property p_no_output;
    @(posedge i_clock) disable iff (!i_rstn)
    cap_mode |=> !o_timer_output;
  endproperty
  a_no_output: assert property (p_no_output)
    else $error("output driven in capture mode");
endmodule : tsp_timer
`default_nettype wire

//--- test/tsp_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module tsp_pin_model (
  input wire logic i_clock,
  input wire logic i_slow,
  input wire logic i_trig_req,
  input wire logic i_cap_req,
  output logic o_ext_trigger_pin,
  output logic o_capture_input_pin
);
  // Request history, one stage per clock
  logic [2:0] trig_dly_ff = 3'h0;
  logic [2:0] cap_dly_ff = 3'h0;
  // Pins move just after an edge, never mid-cycle
  always_ff @(posedge i_clock) begin
    trig_dly_ff <= {trig_dly_ff[1:0], i_trig_req};
    cap_dly_ff <= {cap_dly_ff[1:0], i_cap_req};
  end
  // Slow answer lags three clocks to stress the synchroniser
  assign o_ext_trigger_pin = i_slow ? trig_dly_ff[2] : trig_dly_ff[0];
  assign o_capture_input_pin = i_slow ? cap_dly_ff[2] : cap_dly_ff[0];
endmodule : tsp_pin_model
`default_nettype wire

//--- test/tsp_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin \
  error_cnt++; $display("unexpected at %0t: %s", $time, m); end end
module tsp_timer_tb
  import tsp_pkg::*;
;
  logic clk = 0, rstn = 0, tick = 0, ccs = 0, dps = 0, oil = 0, opol = 0;
  logic on_wr = 0, on_wd = 0, a_wr = 0, slow = 0, trig_req = 0;
  logic cap_req = 0, act;
  logic [1:0] mode = 2'h0, pf = 2'h0;
  logic [15:0] a_wd = 16'h0000;
  logic [15:0] cnt_hold;
  logic [7:0] p_val = 8'h00;
  wire trig_pin, cap_pin, c_on, tout, irq;
  wire [15:0] cnt, cmp_a;
  int error_cnt = 0, cmp_count = 0, n;
  int exp_cap[4] = '{1, 1, 2, 0};
  // 250 MHz clock
  always #2 clk = ~clk;
  tsp_pin_model pins (.i_clock(clk), .i_slow(slow), .i_trig_req(trig_req),
    .i_cap_req(cap_req), .o_ext_trigger_pin(trig_pin),
    .o_capture_input_pin(cap_pin));
  tsp_timer dut (.i_clock(clk), .i_rstn(rstn), .i_tick(tick),
    .i_mode_select_hi(mode[1]), .i_mode_select_lo(mode[0]),
    .i_pin_function_hi(pf[1]), .i_pin_function_lo(pf[0]),
    .i_clear_source_select(ccs), .i_duty_period_swap(dps),
    .i_output_initial_level(oil), .i_output_polarity(opol),
    .i_counter_on_wr(on_wr), .i_counter_on_wdata(on_wd),
    .i_compare_a_wr(a_wr), .i_compare_a_wdata(a_wd),
    .i_compare_p_value(p_val), .i_ext_trigger_pin(trig_pin),
    .i_capture_input_pin(cap_pin), .o_counter_on(c_on), .o_counter(cnt),
    .o_compare_a_value(cmp_a), .o_timer_output(tout), .o_timer_irq(irq));
  // Sample one step after the edge so register updates have landed
  task automatic step(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  // One-cycle write strobes, driven on the edge
  task automatic set_on(logic v);
    @(posedge clk);
    on_wr <= 1'b1;
    on_wd <= v;
    @(posedge clk);
    on_wr <= 1'b0;
  endtask : set_on
  task automatic set_a(logic [15:0] v);
    @(posedge clk);
    a_wr <= 1'b1;
    a_wd <= v;
    @(posedge clk);
    a_wr <= 1'b0;
  endtask : set_a
  task automatic cfg(logic [1:0] m, logic [1:0] f);
    @(posedge clk);
    mode <= m;
    pf <= f;
  endtask : cfg
  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  // Bounded wait; a timeout counts as a mismatch and ends the run
  task automatic wait_for(ref logic s, input int lim, output int cyc);
    cyc = 0;
    do begin
      step(1);
      cyc++;
    end while (s !== 1'b1 && cyc < lim);
    if (s !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask : wait_for
  logic irq_v, on_v;
  always @* irq_v = irq;
  always @* on_v = c_on;
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    tick <= 1'b1;
    step(1);
    `CHK({c_on, cnt, cmp_a, tout, irq}, 35'h0, "reset state")
    // Pulse width from compare A; P, clear source, swap must not matter
    p_val <= 8'h01;
    ccs <= 1'b1;
    dps <= 1'b1;
    cfg(TSP_MODE_PULSE, TSP_PF_SINGLE);
    set_a(16'h0101);
    for (int i = 0; i < 4; i++) begin
      oil <= ~i[0];
      opol <= i[1];
      act = ~i[0] ^ i[1];
      set_on(1'b1);
      wait_for(on_v, 4, n);
      `CHK({cnt, tout}, {16'h0000, act}, "pulse start")
      wait_for(irq_v, 400, n);
      `CHK(n, 258, "pulse width")
      `CHK({c_on, cnt}, {1'b0, 16'h0101}, "match stop")
      step(1);
      `CHK({tout, cnt}, {~act, 16'h0101}, "trailing edge")
    end
    // Trigger pin starts the pulse, slow pin answer
    slow <= 1'b1;
    set_a(16'h0004);
    trig_req <= 1'b1;
    wait_for(on_v, 14, n);
    wait_for(irq_v, 40, n);
    `CHK(cnt, 16'h0004, "triggered pulse end")
    trig_req <= 1'b0;
    slow <= 1'b0;
    // Software clear ends the pulse early, counter keeps its value
    set_a(16'h0100);
    set_on(1'b1);
    step(10);
    set_on(1'b0);
    step(2);
    `CHK({c_on, tout}, {1'b0, ~act}, "software end")
    `CHK(cnt, 16'h000B, "counter kept")
    // Trigger pin refused outside pulse mode
    cfg(TSP_MODE_CAPTURE, TSP_PF_CAP_OFF);
    trig_req <= 1'b1;
    step(12);
    `CHK(c_on, 1'b0, "trigger ignored")
    trig_req <= 1'b0;
    // Each capture edge selection, P zero so no wrap
    p_val <= 8'h00;
    set_on(1'b1);
    for (int f = 0; f < 4; f++) begin
      cfg(TSP_MODE_CAPTURE, f[1:0]);
      n = 0;
      for (int k = 0; k < 24; k++) begin
        @(posedge clk);
        if (k == 2) cap_req <= 1'b1;
        if (k == 13) cap_req <= 1'b0;
        #1;
        if (irq === 1'b1) begin
          n++;
          `CHK(cmp_a, cnt - 16'h0001, "captured value")
        end
      end
      `CHK(n, exp_cap[f], "capture count")
    end
    `CHK({c_on, tout}, 2'b10, "free run, no output")
    // Compare P match wraps the counter
    set_on(1'b0);
    p_val <= 8'h01;
    set_on(1'b1);
    wait_for(irq_v, 300, n);
    // Second match measures one full period
    wait_for(irq_v, 300, n);
    `CHK(n, 256, "P match period")
    `CHK(cnt, 16'h0000, "P match zeroes counter")
    step(2);
    `CHK(cnt[15:3], 13'h0000, "P match clear")
    // Counting only on timer clock ticks
    tick <= 1'b0;
    step(2);
    cnt_hold = cnt;
    step(5);
    `CHK(cnt, cnt_hold, "no tick, no count")
    give_verdict();
  end
endmodule : tsp_timer_tb
`default_nettype wire
